// [core/wwd_defines.svh]
// register indices, field positions, reset values and timing counts
`ifndef WWD_DEFINES_SVH
`define WWD_DEFINES_SVH

`define WWD_IDX_CTRL 6'h2f
`define WWD_IDX_WIN 6'h30
`define WWD_IDX_CFG 6'h31
`define WWD_IDX_STAT 6'h32
`define WWD_IDX_TMIN 6'h33
`define WWD_IDX_TMAX 6'h34

`define WWD_CTRL_ACT_BIT 7
`define WWD_CTRL_TOP_BIT 6
`define WWD_CFG_OIE_BIT 2
`define WWD_CTRL_RESET 8'h7f
`define WWD_WIN_RESET 7'h7f
`define WWD_CNT_ROLL 7'h40

`define WWD_CLK_MHZ 50
`define WWD_PRESC_CYCLES 16384
`define WWD_DEC_UNIT 24'h004000
`define WWD_MAXBASE 24'h004000
`define WWD_MINBASE_ADD 24'h000080
`define WWD_STEP_ADD 24'h0000c0
`define WWD_BASE_MUL 24'h000040
`define WWD_START_SHORT 13'h00ff
`define WWD_START_LONG 13'h0fff
`define WWD_RST_PULSE_NS 30000
`define WWD_RST_CYC ((`WWD_RST_PULSE_NS * `WWD_CLK_MHZ) / 1000)

`endif

// [core/wwd_pkg.sv]
// types shared by the window watchdog
`default_nettype none
package wwd_pkg;

  typedef enum logic [1:0] {
    WWD_RUN = 2'b00,
    WWD_HALT = 2'b01,
    WWD_AHALT = 2'b10,
    WWD_START = 2'b11
  } wwd_mode_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic act;
    logic [6:0] cnt;
    logic [6:0] win;
    logic [1:0] tb;
    logic oscillator_irq_enable;
    logic hw;
    logic hrst;
    logic slong;
    logic [13:0] pre;
    wwd_mode_t mode;
    logic [12:0] dly;
    logic [10:0] rstc;
    logic rst_n;
  } wwd_state_t;

endpackage
`default_nettype wire

// [core/wwd_top.sv]
// window watchdog with low-power handling and a wishbone register slave
// Functional notes
// RULE_01: software keeps top bit set on writes
// RULE_02: low six count bits scale timeout linearly
// RULE_03: min and max base delays added
// RULE_04: timebase select picks major/minor constants
// RULE_05: piecewise minimum timeout formula
// RULE_06: maximum uses same formula, inclusive branch
// RULE_07: all divisions truncate toward zero
// RULE_08: slow and wait leave counting unchanged
// RULE_09: plain halt: decrement once, then freeze
// RULE_10: halt wake waits 256 or 4096 clocks
// RULE_11: reset returns watchdog to disabled state
// RULE_12: halt with reset option raises reset
// RULE_13: active halt freezes counter, no reset
// RULE_14: active halt interrupt exit restarts immediately
// RULE_15: active halt reset exit waits startup
// RULE_16: decrement every 16384 clocks, always running
// RULE_17: activated rollover 40h to 3Fh resets
// RULE_18: activated reload above window resets
// RULE_19: activation bit settable only, reset clears
// RULE_20: tick from shared free-running prescaler
`include "wwd_defines.svh"
`default_nettype none
module wwd_top #(
  parameter int PRESC_CYCLES = `WWD_PRESC_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic halt_req_i,
  input wire logic halt_wake_i,
  input wire logic osc_irq_i,
  input wire logic ext_irq_i,
  input wire logic hw_wdg_opt_i,
  input wire logic halt_rst_opt_i,
  input wire logic startup_long_i,
  output logic mcu_rst_n_o
);

  wwd_pkg::wwd_state_t q;
  wwd_pkg::wwd_state_t d;

  function automatic logic [23:0] wwd_major(input logic [1:0] tb);
    unique case (tb) // see RULE_04
      2'b00: wwd_major = 24'd4;
      2'b01: wwd_major = 24'd8;
      2'b10: wwd_major = 24'd20;
      2'b11: wwd_major = 24'd49;
    endcase
  endfunction

  function automatic logic [23:0] wwd_minor(input logic [1:0] tb);
    unique case (tb) // see RULE_04
      2'b00: wwd_minor = 24'd59;
      2'b01: wwd_minor = 24'd53;
      2'b10: wwd_minor = 24'd35;
      2'b11: wwd_minor = 24'd54;
    endcase
  endfunction

  // timeout in half-oscillator cycles for a loaded count
  function automatic logic [23:0] wwd_timeout(input logic [5:0] cnt,
                                              input logic [1:0] tb,
                                              input logic is_max);
    logic [23:0] c;
    logic [23:0] mj;
    logic [23:0] mn;
    logic [23:0] qt;
    logic [23:0] k;
    logic [23:0] base;
    logic lin;
    c = {18'h0, cnt}; // see RULE_02
    mj = wwd_major(tb);
    mn = wwd_minor(tb);
    qt = mj >> 2; // see RULE_07
    k = (c << 2) / mj; // see RULE_07
    base = is_max ? `WWD_MAXBASE
                  : (mn + `WWD_MINBASE_ADD) * `WWD_BASE_MUL; // see RULE_03
    lin = is_max ? (c <= qt) : (c < qt); // see RULE_05 RULE_06
    if (lin)
    begin
      wwd_timeout = base + `WWD_DEC_UNIT * c;
    end
    else
    begin
      wwd_timeout = base + `WWD_DEC_UNIT * (c - k)
                    + (`WWD_STEP_ADD + mn) * `WWD_BASE_MUL * k;
    end
  endfunction

  logic req;
  logic wr;
  logic [5:0] idx;
  logic tick;
  logic active;
  logic trig;
  logic dec;
  logic [6:0] wcnt;

  assign idx = wb_adr_i[7:2];
  assign req = wb_cyc_i && wb_stb_i;
  // write lands on the edge where the master sees ack
  assign wr = req && wb_we_i && q.ack && wb_sel_i[0];
  // one free-running prescaler feeds the watchdog tick
  assign tick = (q.pre == 14'(PRESC_CYCLES - 1)); // see RULE_20 RULE_16
  assign active = q.act || q.hw;
  assign wcnt = wb_dat_i[6:0];

  always_comb
  begin
    d = q;
    trig = 1'b0;
    dec = 1'b0;
    // prescaler never stops; phase at a write is unknown to software
    d.pre = tick ? 14'h0 : 14'(q.pre + 14'h1); // see RULE_20
    // bus answer: one wait state, ack drops the cycle after
    d.ack = req && !q.ack;
    d.dat = 32'h0;
    if (req && !q.ack && !wb_we_i)
    begin
      unique case (idx)
        `WWD_IDX_CTRL: d.dat = {24'h0, q.act, q.cnt};
        `WWD_IDX_WIN: d.dat = {25'h0, q.win};
        `WWD_IDX_CFG: d.dat = {29'h0, q.oscillator_irq_enable, q.tb};
        `WWD_IDX_STAT: d.dat = {26'h0, q.slong, q.hrst, q.hw, active,
                                q.mode};
        `WWD_IDX_TMIN: d.dat = {8'h0, wwd_timeout(q.cnt[5:0], q.tb, 1'b0)};
        `WWD_IDX_TMAX: d.dat = {8'h0, wwd_timeout(q.cnt[5:0], q.tb, 1'b1)};
        default: d.dat = 32'h0;
      endcase
    end

    // counting: slow and wait modes do not reach this block at all
    unique case (q.mode)
      wwd_pkg::WWD_RUN:
      begin
        if (tick)
        begin
          dec = 1'b1; // see RULE_16 RULE_08
          if (active && q.cnt == `WWD_CNT_ROLL)
          begin
            trig = 1'b1; // see RULE_17
          end
        end
        if (halt_req_i)
        begin
          if (q.oscillator_irq_enable)
          begin
            d.mode = wwd_pkg::WWD_AHALT; // see RULE_13
            dec = 1'b0;
            trig = 1'b0;
          end
          else if (q.hrst)
          begin
            trig = 1'b1; // see RULE_12
          end
          else
          begin
            d.mode = wwd_pkg::WWD_HALT; // see RULE_09
            dec = 1'b1;
            trig = 1'b0;
          end
        end
      end
      wwd_pkg::WWD_HALT:
      begin
        if (halt_wake_i)
        begin
          d.mode = wwd_pkg::WWD_START; // see RULE_10
          d.dly = q.slong ? `WWD_START_LONG : `WWD_START_SHORT;
        end
      end
      wwd_pkg::WWD_AHALT:
      begin
        if (osc_irq_i || ext_irq_i)
        begin
          d.mode = wwd_pkg::WWD_RUN; // see RULE_14
        end
      end
      wwd_pkg::WWD_START:
      begin
        if (q.dly == 13'h0)
        begin
          d.mode = wwd_pkg::WWD_RUN;
        end
        else
        begin
          d.dly = 13'(q.dly - 13'h1);
        end
      end
    endcase
    if (dec)
    begin
      d.cnt = 7'(q.cnt - 7'h1);
    end

    if (wr)
    begin
      unique case (idx)
        `WWD_IDX_CTRL:
        begin
          // activation can only be set; reset alone clears it
          d.act = q.act || wb_dat_i[`WWD_CTRL_ACT_BIT]; // see RULE_19
          d.cnt = wcnt;
          if (active && q.cnt > q.win)
          begin
            trig = 1'b1; // see RULE_18
          end
          if ((d.act || q.hw) && !wcnt[`WWD_CTRL_TOP_BIT - 0])
          begin
            trig = 1'b1; // see RULE_01
          end
        end
        `WWD_IDX_WIN: d.win = wb_dat_i[6:0];
        `WWD_IDX_CFG:
        begin
          d.tb = wb_dat_i[1:0];
          d.oscillator_irq_enable = wb_dat_i[`WWD_CFG_OIE_BIT];
        end
        default: d.win = q.win;
      endcase
    end

    // reset pulse length counted here; retrigger restarts it
    if (trig)
    begin
      d.rstc = 11'(`WWD_RST_CYC);
    end
    else if (q.rstc != 11'h0)
    begin
      d.rstc = 11'(q.rstc - 11'h1);
    end
    d.rst_n = (d.rstc == 11'h0); // see RULE_17

    if (rst_i)
    begin
      d = '0;
      d.act = 1'b0; // see RULE_11
      // activation bit of the reset value is carried by d.act above
      d.cnt = 7'(`WWD_CTRL_RESET);
      d.win = `WWD_WIN_RESET;
      d.rst_n = 1'b1;
      // options are caught while reset is held
      d.hw = hw_wdg_opt_i; // see RULE_11 RULE_19
      d.hrst = halt_rst_opt_i;
      d.slong = startup_long_i;
      // any reset, including one that ends a halt, restarts after delay
      d.mode = wwd_pkg::WWD_START; // see RULE_15 RULE_10
      d.dly = startup_long_i ? `WWD_START_LONG : `WWD_START_SHORT;
    end
  end

  always_ff @(posedge clk_i)
  begin
    q <= d;
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.dat;
  assign mcu_rst_n_o = q.rst_n;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic wr_ctrl;
  assign wr_ctrl = wr && idx == `WWD_IDX_CTRL;

  top_bit_reset_a: assert property ( // see RULE_01
    wr_ctrl && (q.hw || q.act || wb_dat_i[7]) && !wb_dat_i[6]
    |=> !mcu_rst_n_o [*8])
    else $error("clearing top bit did not reset");

  rollover_reset_a: assert property ( // see RULE_17
    q.mode == wwd_pkg::WWD_RUN && tick && active && !halt_req_i
    && q.cnt == 7'h40 && !wr
    |=> !mcu_rst_n_o && q.cnt == 7'h3f)
    else $error("rollover did not reset");

  window_reset_a: assert property ( // see RULE_18
    wr_ctrl && active && q.cnt > q.win |=> !mcu_rst_n_o)
    else $error("reload above window did not reset");

  act_sticky_a: assert property ( // see RULE_19
    q.act |=> q.act)
    else $error("activation bit cleared without reset");

  decrement_a: assert property ( // see RULE_16
    q.mode == wwd_pkg::WWD_RUN && tick && !wr && !halt_req_i
    |=> q.cnt == 7'($past(q.cnt) - 7'h1) && q.pre == 14'h0)
    else $error("tick did not decrement counter");

  ahalt_freeze_a: assert property ( // see RULE_13
    q.mode == wwd_pkg::WWD_RUN && halt_req_i && q.oscillator_irq_enable && !wr
    |=> q.mode == wwd_pkg::WWD_AHALT && q.cnt == $past(q.cnt)
        && mcu_rst_n_o == $past(mcu_rst_n_o || q.rstc == 11'h1))
    else $error("active halt entry wrong");

  halt_reset_a: assert property ( // see RULE_12
    q.mode == wwd_pkg::WWD_RUN && halt_req_i && !q.oscillator_irq_enable && q.hrst
    |=> !mcu_rst_n_o && q.mode == wwd_pkg::WWD_RUN)
    else $error("halt with reset option did not reset");

  halt_once_a: assert property ( // see RULE_09
    q.mode == wwd_pkg::WWD_RUN && halt_req_i && !q.oscillator_irq_enable && !q.hrst && !wr
    |=> q.mode == wwd_pkg::WWD_HALT && q.cnt == 7'($past(q.cnt) - 7'h1)
    ##1 q.cnt == $past(q.cnt))
    else $error("plain halt did not decrement once");

  ahalt_exit_a: assert property ( // see RULE_14
    q.mode == wwd_pkg::WWD_AHALT && (osc_irq_i || ext_irq_i)
    |=> q.mode == wwd_pkg::WWD_RUN)
    else $error("active halt exit not immediate");

  halt_wake_a: assert property ( // see RULE_10
    q.mode == wwd_pkg::WWD_HALT && halt_wake_i && !q.slong
    |=> q.mode == wwd_pkg::WWD_START ##[256:256]
        q.mode == wwd_pkg::WWD_RUN)
    else $error("halt wake delay wrong");

  min_base_a: assert property ( // see RULE_05
    wwd_timeout(6'h00, 2'b00, 1'b0) == 24'd11968
    && wwd_timeout(6'h3f, 2'b00, 1'b1) == 24'd1028416)
    else $error("timeout formula wrong");

  rollover_c: cover property (
    tick && active && q.cnt == 7'h40 ##1 !mcu_rst_n_o);
  window_c: cover property (wr_ctrl && active && q.cnt > q.win);
  ahalt_c: cover property (
    q.mode == wwd_pkg::WWD_AHALT ##1 q.mode == wwd_pkg::WWD_RUN);
  halt_c: cover property (
    q.mode == wwd_pkg::WWD_HALT ##1 q.mode == wwd_pkg::WWD_START);

endmodule
`default_nettype wire

// [sim/wwd_pwr_model.sv]
// power-mode controller model: pulses halt and wake-up events
`default_nettype none
module wwd_pwr_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [1:0] cmd_i,
  output logic halt_req_o = 1'b0,
  output logic halt_wake_o = 1'b0,
  output logic osc_irq_o = 1'b0,
  output logic ext_irq_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // one-cycle pulses, never two kinds at once
  always @(posedge clk_i)
  begin
    halt_req_o <= go_i && cmd_i == 2'h0;
    halt_wake_o <= go_i && cmd_i == 2'h1;
    osc_irq_o <= go_i && cmd_i == 2'h2;
    ext_irq_o <= go_i && cmd_i == 2'h3;
  end
endmodule
`default_nettype wire

// [sim/window_watchdog_timeout_lowpower_bench.sv]
// self-checking bench for the window watchdog
`default_nettype none
module window_watchdog_timeout_lowpower_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // short prescaler keeps the run small
  localparam int PRE = 16;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic go = 1'b0, hopt = 1'b0, hw = 1'b0, slng = 1'b0;
  logic [1:0] cmd = 2'h0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, r, x, dat_o;
  logic ack, rst_n, hrq, hwk, osc, ext;
  int n_errors = 0, num_checks = 0, cycles = 0;
  int maj[4] = '{4, 8, 20, 49};
  int mnr[4] = '{59, 53, 35, 54};
  int cl[6] = '{0, 1, 2, 5, 12, 63};

  wwd_top #(.PRESC_CYCLES(PRE)) wwd_top_i (.clk_i(clk), .rst_i(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .halt_req_i(hrq), .halt_wake_i(hwk), .osc_irq_i(osc),
    .ext_irq_i(ext), .hw_wdg_opt_i(hw), .halt_rst_opt_i(hopt),
    .startup_long_i(slng), .mcu_rst_n_o(rst_n));
  wwd_pwr_model wwd_pwr_model_i (.clk_i(clk), .go_i(go), .cmd_i(cmd),
    .halt_req_o(hrq), .halt_wake_o(hwk), .osc_irq_o(osc),
    .ext_irq_o(ext));

  initial forever #10 clk = ~clk;

  task test_done;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      test_done();
    end
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("wrong value at %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // request held until ack is sampled high, then one idle cycle
  // no local limit: only the bench timeout ends a hung wait
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    wdat <= d;
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
    @(posedge clk);
  endtask

  task rc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(r, e);
  endtask

  task do_rst;
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  task wait_run;
    int n;
    n = 0;
    do
    begin
      wb(1'b0, 8'hc8, 32'h0);
      n++;
    end
    while (r[1:0] !== 2'h0 && n < 200);
  endtask

  task wait_low(input int m);
    int n;
    n = 0;
    while (rst_n !== 1'b0 && n < m)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  task pwr(input logic [1:0] c);
    go <= 1'b1;
    cmd <= c;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  function automatic logic [31:0] tmo(int t, int c, bit mx);
    int k, p;
    k = 4 * c / maj[t];
    p = (mx ? c <= maj[t] / 4 : c < maj[t] / 4) ? 16384 * c
        : 16384 * (c - k) + (192 + mnr[t]) * 64 * k;
    return 32'(mx ? 16384 + p : (mnr[t] + 128) * 64 + p);
  endfunction

  initial
  begin
    do_rst();
    rc(8'hbc, 32'h7f);
    rc(8'hc0, 32'h7f);
    rc(8'hc4, 32'h0);
    wb(1'b1, 8'hfc, 32'hff);
    rc(8'hfc, 32'h0);
    rc(8'hc8, 32'h3);
    wait_run();
    wb(1'b1, 8'hbc, 32'h7f);
    repeat (64) @(posedge clk);
    wb(1'b0, 8'hbc, 32'h0);
    chk(32'(r >= 32'h7a && r <= 32'h7c), 32'h1);
    // plain halt first, then active halt: counter stands in both
    for (int i = 0; i < 2; i++)
    begin
      wb(1'b1, 8'hc4, 32'(4 * i));
      pwr(2'h0);
      rc(8'hc8, 32'(i + 1));
      wb(1'b0, 8'hbc, 32'h0);
      x = r;
      repeat (64) @(posedge clk);
      rc(8'hbc, x);
      if (i == 0)
      begin
        pwr(2'h1);
        repeat (230) @(posedge clk);
        rc(8'hc8, 32'h3);
        wait_run();
      end
    end
    // frozen counter lets the timeout table be read race-free
    foreach (cl[j])
      for (int t = 0; t < 4; t++)
      begin
        wb(1'b1, 8'hc4, 32'(4 + t));
        wb(1'b1, 8'hbc, 32'(8'h40 + cl[j]));
        rc(8'hcc, tmo(t, cl[j], 0));
        rc(8'hd0, tmo(t, cl[j], 1));
      end
    pwr(2'h2);
    rc(8'hc8, 32'h0);
    pwr(2'h0);
    pwr(2'h3);
    rc(8'hc8, 32'h0);
    wb(1'b1, 8'hbc, 32'hff);
    wb(1'b1, 8'hbc, 32'h7f);
    wb(1'b0, 8'hbc, 32'h0);
    chk({31'h0, r[7]}, 32'h1);
    chk({31'h0, rst_n}, 32'h1);
    wb(1'b1, 8'hc0, 32'h50);
    wb(1'b1, 8'hbc, 32'hff);
    wait_low(4);
    chk({31'h0, rst_n}, 32'h0);
    do_rst();
    wb(1'b0, 8'hbc, 32'h0);
    chk({31'h0, r[7]}, 32'h0);
    wb(1'b1, 8'hbc, 32'hc1);
    wait_low(700);
    chk({31'h0, rst_n}, 32'h0);
    do_rst();
    wb(1'b1, 8'hbc, 32'h80);
    wait_low(4);
    chk({31'h0, rst_n}, 32'h0);
    hopt <= 1'b1;
    do_rst();
    wait_run();
    pwr(2'h0);
    chk({31'h0, rst_n}, 32'h0);
    hopt <= 1'b0;
    // hardware option keeps it active; long option stretches startup
    hw <= 1'b1;
    slng <= 1'b1;
    do_rst();
    rc(8'hc8, 32'h2f);
    repeat (4000) @(posedge clk);
    rc(8'hc8, 32'h2f);
    wait_run();
    rc(8'hc8, 32'h2c);
    wb(1'b1, 8'hbc, 32'h3f);
    wait_low(4);
    chk({31'h0, rst_n}, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
